// file: inc/pls_defines.svh
/*
  Offsets, field positions, reset values and timing counts for the link status flags.
  Assumes the including file needs plain macros only; no types live here.
*/
`ifndef PLS_DEFINES_SVH
`define PLS_DEFINES_SVH

`define PLS_STATUS_ADDR    5'h12
`define PLS_BIT_MGMT_INT   15
`define PLS_BIT_POWER_OK   14
`define PLS_BIT_POL_OK     13
`define PLS_BIT_ENERGY     12
`define PLS_BIT_SYNC_LOST  11
`define PLS_BIT_FAR_FAULT  10
`define PLS_RESERVED_VAL   10'h000
`define PLS_POL_OK_RST     1'b1
`define PLS_SYS_CLK_MHZ    25
`define PLS_IDLE_WINDOW_US 722
`define PLS_IDLE_WINDOW_CYC (`PLS_IDLE_WINDOW_US * `PLS_SYS_CLK_MHZ)
`define PLS_IDLE_RUN       12
`define PLS_INV_PULSES     7
`define PLS_ENERGY_HOLD    64

`endif

// file: inc/pls_pkg.sv
/*
  Types shared by the link status flag logic.
  Assumes the defines header is compiled alongside for the numeric constants.
*/
package pls_pkg;

  // Symbol and pulse indications from the receive path, on the link clock.
  typedef struct packed {
    logic sym_valid;
    logic idle_sym;
    logic fef_seq;
    logic link_pulse;
    logic pulse_inverted;
  } pls_link_in_t;

  // Layout of the status word as read by station management.
  typedef struct packed {
    logic       mgmt_interrupt_flag;
    logic       power_ok;
    logic       polarity_ok;
    logic       line_energy_detect;
    logic       descrambler_sync_lost;
    logic       far_end_fault_flag;
    logic [9:0] reserved;
  } pls_status_t;

endpackage

// file: core/pls_status.sv
/*
  Upper status flags of the transceiver: polarity, line energy, descrambler
  sync watchdog, far-end fault and the management interrupt latch.
  Assumes the control bits arrive on sys_clk_i from the control register,
  the receive path drives link_in_i on link_clk_i, and the receive pair pins
  are asynchronous to both clocks.
*/
// Overview of operation
// - Leaving manual mode with polarity bad keeps it bad until swap toggles.
// - Outside manual mode a swap toggle sets polarity good; in manual mode it arms, and the next good pulse restores it.
// - Polarity is judged from link pulses only, never data or idles.
// - Bit 12 reads one while impulses arrive on the receive pair.
// - At 100 Mbit/s, twelve idles must arrive each 722 us, else bit 11 sets.
// - A failed idle check restarts descrambler synchronisation.
// - Sync loss stays set until the status register is read.
// - Far-end fault sets bit 10 only while its enable is on.
// - Far-end fault stays set until the status register is read.
// - Bits 9 to 0 read zero; software writes only zero there.
// - In manual mode, seven consecutive inverted pulses clear polarity good.
// - Sync loss or far-end fault setting raises the interrupt flag, latched.
// - In manual mode, energy rising or polarity change also raise it.
// - The interrupt request holds until read; writes cannot touch it.
`timescale 1ns/1ps
`include "pls_defines.svh"

module pls_status #(
  parameter int unsigned IDLE_WINDOW_CYC = `PLS_IDLE_WINDOW_CYC,
  parameter int unsigned ENERGY_HOLD     = `PLS_ENERGY_HOLD
) (
  input  wire logic                 sys_clk_i,               // Management clock.
  input  wire logic                 sys_rst_i,               // Async reset, high.
  input  wire logic                 link_clk_i,              // Recovered link clock.
  input  wire pls_pkg::pls_link_in_t link_in_i,              // Receive path flags.
  input  wire logic                 receive_pair_pos_i,      // Receive pair, plus.
  input  wire logic                 receive_pair_neg_i,      // Receive pair, minus.
  input  wire logic                 speed_100_i,             // 100 Mbit/s mode.
  input  wire logic                 manual_polarity_config_i,// Manual polarity.
  input  wire logic                 swap_polarity_i,         // Polarity swap bit.
  input  wire logic                 far_end_fault_enable_i,  // Far-end fault enable.
  input  wire logic                 power_ok_i,              // Oscillator running.
  input  wire logic                 rd_en_i,                 // Register read strobe.
  input  wire logic [4:0]           rd_addr_i,               // Register address.
  output logic [15:0]               rd_data_o,               // Read data.
  output logic                      rd_valid_o,              // Read data valid.
  output logic                      polarity_ok_o,           // Polarity good.
  output logic                      line_energy_detect_o,    // Energy on pair.
  output logic                      descrambler_sync_lost_o, // Sync loss latch.
  output logic                      far_end_fault_flag_o,    // Far-end fault latch.
  output logic                      mgmt_irq_o,              // Interrupt request.
  output logic                      descrambler_resync_o     // Resync pulse, link.
);
  import pls_pkg::*;

  localparam int unsigned WW = $clog2(IDLE_WINDOW_CYC + 1);
  localparam int unsigned EW = $clog2(ENERGY_HOLD + 1);

  // A toggle that differs from its delayed copy marks one event.
  function automatic logic tgl_evt(input logic cur, input logic prev);
    tgl_evt = cur ^ prev;
  endfunction

  // Link-domain reset: asserted at once, released on the link clock.
  logic [1:0] link_rst_q;
  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_rst_q <= 2'h0;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'b1};
    end
  end

  logic [3:0] idle_cnt;
  logic [3:0] next_idle_cnt;
  logic       idle_tgl;
  logic       next_idle_tgl;
  logic       pok_tgl;
  logic       next_pok_tgl;
  logic       pinv_tgl;
  logic       next_pinv_tgl;
  logic [2:0] rsy_s;
  logic       next_resync;
  logic       resync_tgl;

  // Link side: count idle runs, report pulses, deliver the resync request.
  always_comb begin
    next_idle_cnt = idle_cnt;
    next_idle_tgl = idle_tgl;
    next_pok_tgl  = pok_tgl;
    next_pinv_tgl = pinv_tgl;
    next_resync   = tgl_evt(rsy_s[2], rsy_s[1]);
    if (link_in_i.sym_valid) begin
      if (!link_in_i.idle_sym) begin
        next_idle_cnt = 4'h0;
      end else if (idle_cnt < 4'(`PLS_IDLE_RUN)) begin
        next_idle_cnt = idle_cnt + 4'h1;
        if (idle_cnt == 4'(`PLS_IDLE_RUN - 1)) begin
          next_idle_tgl = ~idle_tgl;
        end
      end
    end
    if (next_resync) begin
      next_idle_cnt = 4'h0;
    end
    if (link_in_i.link_pulse) begin
      if (link_in_i.pulse_inverted) begin
        next_pinv_tgl = ~pinv_tgl;
      end else begin
        next_pok_tgl = ~pok_tgl;
      end
    end
  end

  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_cnt             <= 4'h0;
      idle_tgl             <= 1'b0;
      pok_tgl              <= 1'b0;
      pinv_tgl             <= 1'b0;
      rsy_s                <= 3'h0;
      descrambler_resync_o <= 1'b0;
    end else if (!link_rst_q[1]) begin
      idle_cnt             <= 4'h0;
      idle_tgl             <= 1'b0;
      pok_tgl              <= 1'b0;
      pinv_tgl             <= 1'b0;
      rsy_s                <= 3'h0;
      descrambler_resync_o <= 1'b0;
    end else begin
      idle_cnt             <= next_idle_cnt;
      idle_tgl             <= next_idle_tgl;
      pok_tgl              <= next_pok_tgl;
      pinv_tgl             <= next_pinv_tgl;
      rsy_s                <= {rsy_s[1:0], resync_tgl};
      descrambler_resync_o <= next_resync;
    end
  end

  // Synchronisers into the management clock; the third stage is the delayed
  // copy for toggle edges, so the first stage feeds only the second.
  logic [5:0] s1;
  logic [5:0] s2;
  logic [5:0] s3;
  logic [5:0] raw;
  assign raw = {receive_pair_pos_i, receive_pair_neg_i, link_in_i.fef_seq,
                idle_tgl, pok_tgl, pinv_tgl};

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1 <= 6'h00;
      s2 <= 6'h00;
      s3 <= 6'h00;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  logic impulse;
  logic fef_seen;
  logic idle_evt;
  logic pok_evt;
  logic pinv_evt;
  assign impulse  = s2[5] | s2[4];
  assign fef_seen = s2[3];
  assign idle_evt = tgl_evt(s2[2], s3[2]);
  assign pok_evt  = tgl_evt(s2[1], s3[1]);
  assign pinv_evt = tgl_evt(s2[0], s3[0]);

  logic [WW-1:0] win_cnt;
  logic [WW-1:0] next_win_cnt;
  logic [EW-1:0] en_cnt;
  logic [EW-1:0] next_en_cnt;
  logic [2:0]    inv_cnt;
  logic [2:0]    next_inv_cnt;
  logic          next_resync_tgl;
  logic          rearm;
  logic          next_rearm;
  logic          swap_prev;
  logic          next_pol;
  logic          next_energy;
  logic          next_sync_lost;
  logic          next_fef;
  logic          next_mgmt_interrupt_flag;
  logic          next_rd_valid;
  logic [15:0]   next_rd_data;
  logic          rd_hit;
  logic          sl_set;
  logic          fef_set;
  pls_status_t   stat;

  // Status word as it stands this cycle; reserved bits forced to zero.
  always_comb begin
    stat.mgmt_interrupt_flag   = mgmt_irq_o;
    stat.power_ok              = power_ok_i;
    stat.polarity_ok           = polarity_ok_o;
    stat.line_energy_detect    = line_energy_detect_o;
    stat.descrambler_sync_lost = descrambler_sync_lost_o;
    stat.far_end_fault_flag    = far_end_fault_flag_o;
    stat.reserved              = `PLS_RESERVED_VAL;
  end

  // Management side: watchdog, energy, polarity, latches and read port.
  always_comb begin
    next_win_cnt    = win_cnt;
    next_resync_tgl = resync_tgl;
    next_en_cnt     = en_cnt;
    next_inv_cnt    = inv_cnt;
    next_rearm      = rearm;
    next_pol        = polarity_ok_o;
    sl_set          = 1'b0;
    rd_hit          = rd_en_i && (rd_addr_i == `PLS_STATUS_ADDR);
    if (!speed_100_i || idle_evt) begin
      next_win_cnt = '0;
    end else if (win_cnt == WW'(IDLE_WINDOW_CYC - 1)) begin
      next_win_cnt    = '0;
      sl_set          = 1'b1;
      next_resync_tgl = ~resync_tgl;
    end else begin
      next_win_cnt = win_cnt + WW'(1);
    end
    if (impulse) begin
      next_en_cnt = EW'(ENERGY_HOLD);
    end else if (en_cnt != '0) begin
      next_en_cnt = en_cnt - EW'(1);
    end
    next_energy = (next_en_cnt != '0);
    if (!polarity_ok_o) begin
      next_inv_cnt = 3'h0;
      if (swap_polarity_i != swap_prev) begin
        if (!manual_polarity_config_i) begin
          next_pol = 1'b1;
        end else begin
          next_rearm = 1'b1;
        end
      end
      if (rearm && pok_evt && manual_polarity_config_i) begin
        next_pol   = 1'b1;
        next_rearm = 1'b0;
      end
      if (!manual_polarity_config_i && next_pol) begin
        next_rearm = 1'b0;
      end
    end else if (manual_polarity_config_i) begin
      if (pinv_evt) begin
        if (inv_cnt == 3'(`PLS_INV_PULSES - 1)) begin
          next_pol     = 1'b0;
          next_inv_cnt = 3'h0;
        end else begin
          next_inv_cnt = inv_cnt + 3'h1;
        end
      end else if (pok_evt) begin
        next_inv_cnt = 3'h0;
      end
    end else begin
      next_inv_cnt = 3'h0;
    end
    fef_set = far_end_fault_enable_i && fef_seen;
    next_sync_lost = sl_set | (descrambler_sync_lost_o & ~rd_hit);
    next_fef = fef_set | (far_end_fault_flag_o & ~rd_hit);
    next_mgmt_interrupt_flag = sl_set | fef_set | (mgmt_irq_o & ~rd_hit);
    if (manual_polarity_config_i &&
        ((next_energy && !line_energy_detect_o) || (next_pol != polarity_ok_o))) begin
      next_mgmt_interrupt_flag = 1'b1;
    end
    next_rd_valid = rd_en_i;
    next_rd_data  = rd_hit ? 16'(stat) : 16'h0000;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      win_cnt                 <= '0;
      en_cnt                  <= '0;
      inv_cnt                 <= 3'h0;
      resync_tgl              <= 1'b0;
      rearm                   <= 1'b0;
      swap_prev               <= 1'b0;
      polarity_ok_o           <= `PLS_POL_OK_RST;
      line_energy_detect_o    <= 1'b0;
      descrambler_sync_lost_o <= 1'b0;
      far_end_fault_flag_o    <= 1'b0;
      mgmt_irq_o              <= 1'b0;
      rd_valid_o              <= 1'b0;
      rd_data_o               <= 16'h0000;
    end else begin
      win_cnt                 <= next_win_cnt;
      en_cnt                  <= next_en_cnt;
      inv_cnt                 <= next_inv_cnt;
      resync_tgl              <= next_resync_tgl;
      rearm                   <= next_rearm;
      swap_prev               <= swap_polarity_i;
      polarity_ok_o           <= next_pol;
      line_energy_detect_o    <= next_energy;
      descrambler_sync_lost_o <= next_sync_lost;
      far_end_fault_flag_o    <= next_fef;
      mgmt_irq_o              <= next_mgmt_interrupt_flag;
      rd_valid_o              <= next_rd_valid;
      rd_data_o               <= next_rd_data;
    end
  end

endmodule

// file: tb/pls_status_asserts.sv
/* Concurrent checks on the ports of pls_status, all on the sys clock.
   Assumes it is bound to pls_status and sees only that module's ports. */
`timescale 1ns/1ps
module pls_status_asserts (
  input wire logic        sys_clk_i,                // Clock.
  input wire logic        sys_rst_i,                // Reset.
  input wire logic        rd_en_i,                  // Read strobe.
  input wire logic [4:0]  rd_addr_i,                // Address.
  input wire logic [15:0] rd_data_o,                // Read data.
  input wire logic        rd_valid_o,               // Read valid.
  input wire logic        manual_polarity_config_i, // Manual mode.
  input wire logic        swap_polarity_i,          // Swap bit.
  input wire logic        far_end_fault_enable_i,   // Fault enable.
  input wire logic        polarity_ok_o,            // Polarity good.
  input wire logic        line_energy_detect_o,     // Energy.
  input wire logic        descrambler_sync_lost_o,  // Sync loss.
  input wire logic        far_end_fault_flag_o,     // Far fault.
  input wire logic        mgmt_irq_o                // Interrupt.
);
  // A status read; the latches may only drop at such an edge.
  logic hit;
  assign hit = rd_en_i && rd_addr_i == 5'h12;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd; hit; endsequence
  sequence s_ans; rd_valid_o && rd_data_o[9:0] == 10'h000; endsequence
  property p_rd; s_rd |=> s_ans; endproperty
  a_rd: assert property (p_rd) else $error("bad read answer");
  property p_word;
    s_rd |=> rd_data_o[15] == $past(mgmt_irq_o) && rd_data_o[13:10] == $past({polarity_ok_o,
      line_energy_detect_o, descrambler_sync_lost_o, far_end_fault_flag_o});
  endproperty
  a_word: assert property (p_word) else $error("read word wrong");
  property p_sl; descrambler_sync_lost_o && !hit |=> descrambler_sync_lost_o; endproperty
  a_sl: assert property (p_sl) else $error("sync loss dropped");
  property p_ff; far_end_fault_flag_o && !hit |=> far_end_fault_flag_o; endproperty
  a_ff: assert property (p_ff) else $error("far fault dropped");
  property p_irq; mgmt_irq_o && !hit |=> mgmt_irq_o; endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped");
  property p_fen; $rose(far_end_fault_flag_o) |-> $past(far_end_fault_enable_i); endproperty
  a_fen: assert property (p_fen) else $error("far fault while off");
  property p_src;
    $rose(descrambler_sync_lost_o) || $rose(far_end_fault_flag_o) |-> mgmt_irq_o;
  endproperty
  a_src: assert property (p_src) else $error("no interrupt");
  property p_keep;
    !polarity_ok_o && !manual_polarity_config_i && $stable(swap_polarity_i)
      && swap_polarity_i == $past(swap_polarity_i, 2) |=> !polarity_ok_o;
  endproperty
  a_keep: assert property (p_keep) else $error("polarity rose early");
  property p_clr; $fell(polarity_ok_o) |-> $past(manual_polarity_config_i); endproperty
  a_clr: assert property (p_clr) else $error("polarity cleared in auto");
endmodule

bind pls_status pls_status_asserts i_pls_status_asserts (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .manual_polarity_config_i(manual_polarity_config_i), .swap_polarity_i(swap_polarity_i),
  .far_end_fault_enable_i(far_end_fault_enable_i), .polarity_ok_o(polarity_ok_o),
  .line_energy_detect_o(line_energy_detect_o), .mgmt_irq_o(mgmt_irq_o),
  .descrambler_sync_lost_o(descrambler_sync_lost_o),
  .far_end_fault_flag_o(far_end_fault_flag_o));

// file: tb/pls_link_model.sv
/* Receive-path model: symbols, link pulses and far-end fault signalling.
   Assumes the bench calls its tasks and sets fef; all changes follow link edges. */
`timescale 1ns/1ps
module pls_link_model (
  input  wire logic           clk_i, // Link clock.
  output pls_pkg::pls_link_in_t li_o   // Indications.
);
  import pls_pkg::*;
  logic fef = 1'b0;
  logic f = 1'b0, sv = 1'b0, id = 1'b0, lp = 1'b0, inv = 1'b0;
  // The fault level is retimed so it only moves after a link edge.
  always @(posedge clk_i) f <= fef;
  assign li_o = '{sym_valid: sv, idle_sym: id, fef_seq: f, link_pulse: lp, pulse_inverted: inv};
  // A run of n idles, then data; the data keeps runs from merging.
  task automatic burst(input int n);
    repeat (n) @(posedge clk_i) {sv, id} <= 2'b11;
    repeat (30) @(posedge clk_i) {sv, id} <= 2'b10;
    @(posedge clk_i) {sv, id} <= 2'b00;
  endtask
  // One link pulse; the sense bit flips afterwards so stale values never pass.
  task automatic pulse(input logic i);
    @(posedge clk_i) {lp, inv} <= {1'b1, i};
    @(posedge clk_i) {lp, inv} <= {1'b0, ~i};
    repeat (20) @(posedge clk_i);
  endtask
endmodule

// file: tb/pls_status_bench.sv
/* Self-checking bench for pls_status with short windows.
   Assumes the link model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module pls_status_bench;
  import pls_pkg::*;
  localparam int WIN = 200;
  localparam int HOLD = 8;
  typedef struct packed { logic [4:0] a; logic p; logic [15:0] d; } pls_row_t;
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, re, pp, pn, spd, man, swp, fen, pok;
  logic [4:0] ra;
  logic [15:0] rd;
  logic rv, pol, en, sl, ff, irq, rs;
  pls_link_in_t li;
  int fail_count = 0, checks_done = 0, cyc = 0, rsn = 0;
  pls_row_t rows [4] = '{'{5'h12, 1'b1, 16'h6000}, '{5'h12, 1'b0, 16'h2000},
                         '{5'h00, 1'b1, 16'h0000}, '{5'h1f, 1'b1, 16'h0000}};
  // Clocks; the link clock is offset so the two never line up by design.
  initial forever #20 clk = ~clk;
  initial begin
    #3;
    forever #7.5 lclk = ~lclk;
  end
  // Cut a hang short and count resync pulses on the link side.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  always @(posedge lclk) if (rs === 1'b1) rsn <= rsn + 1;
  pls_status #(.IDLE_WINDOW_CYC(WIN), .ENERGY_HOLD(HOLD)) i_pls_status (
    .sys_clk_i(clk), .sys_rst_i(rst), .link_clk_i(lclk), .link_in_i(li),
    .receive_pair_pos_i(pp), .receive_pair_neg_i(pn), .speed_100_i(spd),
    .manual_polarity_config_i(man), .swap_polarity_i(swp), .far_end_fault_enable_i(fen),
    .power_ok_i(pok), .rd_en_i(re), .rd_addr_i(ra), .rd_data_o(rd), .rd_valid_o(rv),
    .polarity_ok_o(pol), .line_energy_detect_o(en), .descrambler_sync_lost_o(sl),
    .far_end_fault_flag_o(ff), .mgmt_irq_o(irq), .descrambler_resync_o(rs));
  pls_link_model i_pls_link_model (.clk_i(lclk), .li_o(li));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One read: strobe for a single edge, answer sampled a cycle later.
  task automatic rdr(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    re = 1'b1;
    ra = a;
    @(negedge clk);
    re = 1'b0;
    d = rd;
    chk("rd_valid", 16'h0001, {15'h0, rv});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    logic [15:0] d;
    {re, pp, pn, spd, man, swp, fen, pok} = 8'h00;
    ra = 5'h00;
    w(8);
    chk("pol_reset", 16'h0001, {15'h0, pol});
    rst = 1'b0;
    // Table of reads, unmapped addresses among them.
    foreach (rows[i]) begin
      pok = rows[i].p;
      w(2);
      rdr(rows[i].a, d);
      chk("row", rows[i].d, d);
    end
    // Idle watchdog: twelve idles suffice, eleven do not.
    spd = 1'b1;
    repeat (15) i_pls_link_model.burst(12);
    w(1);
    chk("sync_ok", 16'h0000, {15'h0, sl});
    repeat (17) i_pls_link_model.burst(11);
    w(1);
    chk("sync_lost", 16'h0001, {15'h0, sl});
    chk("resync", 16'h0001, {15'h0, rsn != 0});
    chk("irq_sync", 16'h0001, {15'h0, irq});
    spd = 1'b0;
    w(4);
    rdr(5'h12, d);
    chk("rd_sync", 16'h0001, {15'h0, d[11]});
    chk("sync_clr", 16'h0000, {15'h0, sl});
    chk("irq_clr", 16'h0000, {15'h0, irq});
    // Far-end fault: gated by enable, re-set while present, held after.
    i_pls_link_model.fef = 1'b1;
    w(10);
    chk("fef_off", 16'h0000, {15'h0, ff});
    fen = 1'b1;
    w(2);
    chk("fef_on", 16'h0001, {15'h0, ff});
    rdr(5'h12, d);
    w(1);
    chk("fef_again", 16'h0001, {15'h0, ff});
    i_pls_link_model.fef = 1'b0;
    w(10);
    chk("fef_hold", 16'h0001, {15'h0, ff});
    rdr(5'h12, d);
    chk("fef_rd", 16'h0001, {15'h0, d[10]});
    chk("fef_clr", 16'h0000, {15'h0, ff});
    // Polarity: six inverted pulses are not enough, the seventh clears it.
    fen = 1'b0;
    man = 1'b1;
    rdr(5'h12, d);
    repeat (6) i_pls_link_model.pulse(1'b1);
    i_pls_link_model.pulse(1'b0);
    repeat (6) i_pls_link_model.pulse(1'b1);
    w(4);
    chk("pol_six", 16'h0001, {15'h0, pol});
    // Idles and data in between must not reset the inverted-pulse run.
    i_pls_link_model.burst(12);
    i_pls_link_model.pulse(1'b1);
    w(4);
    chk("pol_seven", 16'h0000, {15'h0, pol});
    chk("irq_pol", 16'h0001, {15'h0, irq});
    // In manual mode a swap only arms; one good pulse then restores polarity.
    swp = 1'b1;
    w(3);
    chk("pol_armed", 16'h0000, {15'h0, pol});
    i_pls_link_model.pulse(1'b0);
    w(4);
    chk("pol_rearm", 16'h0001, {15'h0, pol});
    repeat (7) i_pls_link_model.pulse(1'b1);
    w(4);
    chk("pol_again", 16'h0000, {15'h0, pol});
    // Leaving manual mode with polarity bad keeps it bad until a swap.
    man = 1'b0;
    w(10);
    chk("pol_keep", 16'h0000, {15'h0, pol});
    swp = 1'b0;
    w(3);
    chk("pol_swap", 16'h0001, {15'h0, pol});
    // Energy on either pin; it interrupts only in manual mode.
    for (int m = 0; m < 2; m++) begin
      man = m[0];
      rdr(5'h12, d);
      {pn, pp} = m[0] ? 2'b10 : 2'b01;
      w(1);
      {pn, pp} = 2'b00;
      w(4);
      chk("energy", 16'h0001, {15'h0, en});
      chk("irq_energy", {15'h0, m[0]}, {15'h0, irq});
      w(HOLD + 4);
      chk("energy_off", 16'h0000, {15'h0, en});
    end
    // Mid-run reset with a fault present: latches clear, then set again.
    fen = 1'b1;
    i_pls_link_model.fef = 1'b1;
    w(6);
    rst = 1'b1;
    w(2);
    chk("ff_rst", 16'h0000, {15'h0, ff});
    chk("irq_rst", 16'h0000, {15'h0, irq});
    chk("pol_rst", 16'h0001, {15'h0, pol});
    rst = 1'b0;
    w(5);
    chk("ff_after_rst", 16'h0001, {15'h0, ff});
    chk("irq_after_rst", 16'h0001, {15'h0, irq});
    i_pls_link_model.fef = 1'b0;
    end_of_test();
  end
endmodule
